/* core/adcc_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_OFS_SC1 16'h0010
`define ADCC_OFS_SC2 16'h0011
`define ADCC_OFS_SC3 16'h0012
`define ADCC_OFS_SC4 16'h0013
`define ADCC_OFS_RH 16'h0014
`define ADCC_OFS_RL 16'h0015
`define ADCC_OFS_CVH 16'h0016
`define ADCC_OFS_CVL 16'h0017
`define ADCC_OFS_PCTL 16'h30ac
`define ADCC_RST_SC1 8'h1f
`define ADCC_RST_SC2 8'h08
`define ADCC_RST_ZERO 8'h00
`define ADCC_BIT_DONE 7
`define ADCC_BIT_IEN 6
`define ADCC_BIT_CONT 5
`define ADCC_BIT_HWTRG 6
`define ADCC_BIT_CMPEN 5
`define ADCC_BIT_CMPGT 4
`define ADCC_BIT_FEMPTY 3
`define ADCC_BIT_FFULL 2
`define ADCC_BIT_ACT 7
`define ADCC_CH_OFF 5'h1f
`define ADCC_CONV_TIME_NS 1000
`define ADCC_CLK_NS 10
`define ADCC_CONV_CYCLES ((`ADCC_CONV_TIME_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`endif

/* core/adcc_pkg.sv */
// Types shared by the converter control block
package adcc_pkg;
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_CONV = 3'b010,
    ADCC_WAIT = 3'b100
  } adcc_state_t;
  typedef logic [4:0] adcc_chan_t;
endpackage

/* core/adcc_queue_if.sv */
// Channel queue connection between control and queue store
`timescale 1ns/10ps
interface adcc_queue_if;
  logic push;
  logic clear;
  logic [4:0] push_chan;
  logic [3:0] rd_ptr;
  logic [4:0] rd_chan;
  logic [3:0] count;
  modport ctrl (output push, output clear, output push_chan, output rd_ptr,
    input rd_chan, input count);
  modport store (input push, input clear, input push_chan, input rd_ptr,
    output rd_chan, output count);
endinterface

/* core/adcc_queue.sv */
// Channel queue store, kept in write order
`timescale 1ns/10ps
module adcc_queue #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  adcc_queue_if.store q
);
  import adcc_pkg::*;
  adcc_chan_t mem [DEPTH];
  logic [3:0] count;
  initial begin
    if (DEPTH < 1 || DEPTH > 8) $error("queue depth must be 1..8");
  end
  // Push appends at count; clear empties
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 4'h0;
    end else if (q.clear) begin
      count <= 4'h0;
    end else if (q.push && count < 4'(DEPTH)) begin
      count <= count + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (q.push && !q.clear && count < 4'(DEPTH)) begin
      mem[count[2:0]] <= q.push_chan;
    end
  end
  assign q.count = count;
  assign q.rd_chan = mem[q.rd_ptr[2:0]];
endmodule

/* core/adcc_ctrl.sv */
// Conversion control registers and sequencing for the converter
`timescale 1ns/10ps
`include "adcc_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Block outline
// Software owns the block through a byte-wide register port.
// Reads answer one cycle after the strobe, writes land at once.
// The first control register starts, aborts and stops conversions.
// Channel code all ones parks the converter and empties the queue.
// Queue mode collects channel codes until the set is complete.
// The converter itself sits outside; it returns a ten-bit sample.
// Sample_strobe marks the cycle in which that sample is taken.
// Conversion time is a count of bus clocks, set by parameter.
// Hardware trigger comes from a pin, so it is filtered first.
// Done flag and interrupt enable combine into a level request.
//
// Register map, byte offsets
//   0x10 control one: flag, interrupt enable, continuous, channel
//   0x11 control two: busy, trigger select, compare on, compare sense, queue flags
//   0x12 control three: plain storage here
//   0x13 control four: queue depth in the low three bits
//   0x14 result high: two top result bits, read only
//   0x15 result low: eight low bits, read only, reading clears the flag
//   0x16 compare high: two top reference bits used
//   0x17 compare low: eight low reference bits
//   0x30ac pin control: plain storage here
//
// Hazards worth knowing
// Outside queue mode, a software-mode control write aborts a running conversion at once.
// In trigger mode a control write restarts nothing; only all ones halts.
// In software mode, a write that completes the queue starts the set on the same edge.
// A write to an already full queue empties it; that code is dropped.
// Trigger edges that arrive while busy are ignored, not remembered.
// Results are only kept when the compare condition holds.
// Read data are zero outside the read slot, so buses may be ORed.
// Conversion count is fixed per build; slower clocks mean longer waits.
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Control write aborts, restarts unless channel off (here only in software mode, outside queue mode or on the write that completes the queue)
// - Queue mode: channel writes push queue
// - Queue converts in write order
// - Queue waits until programmed depth filled
// - Channel all ones empties queue, halts
// - Done flag bit 7 on completion
// - Compare on: done only if match
// - Queue mode: done once per set
// - Done clears on control write, low read
// - Interrupt when done sets, enable bit 6
// - Single software mode: one per write
// - Single hardware mode: one per trigger
// - Single queue mode: one set per trigger
// - Control register resets to 1Fh
// - Results read-only at 14, 15
// - Compare values read-write at 16, 17
// - Pin control read-write at 30AC
// - Channel field 5 bits, 11111 off
// - Continuous mode repeats, loops queue set
module adcc_ctrl #(
  parameter int QDEPTH = 8,
  parameter int CONV_CYCLES = `ADCC_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic hardware_trigger_input,
  input wire logic [9:0] sample_data,
  output logic [4:0] active_channel,
  output logic sample_strobe,
  output logic done_irq
);
  import adcc_pkg::*;
  initial begin
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) $error("bad conversion count");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] status_control_one;
  logic [7:0] status_control_two;
  logic [7:0] status_control_three;
  logic [7:0] status_control_four;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic [7:0] compare_value_high;
  logic [7:0] compare_value_low;
  logic [7:0] pin_control_one;
  logic conversion_done_flag;
  adcc_state_t state;
  adcc_state_t next_state;
  logic [15:0] timer;
  logic [3:0] qidx;
  adcc_queue_if qi();
  adcc_queue #(.DEPTH(QDEPTH)) u_queue (
    .clk(clk),
    .rst(rst),
    .q(qi)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Decode and field views
  wire sel_sc1 = addr == `ADCC_OFS_SC1;
  wire wr_sc1 = wr && sel_sc1;
  wire rd_rl = rd && addr == `ADCC_OFS_RL;
  wire [4:0] channel_select = status_control_one[4:0];
  wire [4:0] wr_chan = wdata[4:0];
  wire done_interrupt_enable = status_control_one[`ADCC_BIT_IEN];
  wire continuous_enable = status_control_one[`ADCC_BIT_CONT];
  wire hw_mode = status_control_two[`ADCC_BIT_HWTRG];
  wire compare_enable = status_control_two[`ADCC_BIT_CMPEN];
  wire compare_gt = status_control_two[`ADCC_BIT_CMPGT];
  wire [2:0] queue_depth = status_control_four[2:0];
  wire fifo_mode = queue_depth != 3'h0;
  // Queue holds depth+1 entries, so depth field 0 means no queue
  wire [3:0] set_len = {1'b0, queue_depth} + 4'h1;
  wire queue_full = qi.count >= set_len;
  wire chan_off = wr_chan == `ADCC_CH_OFF;
  ////////////////////////////////////////////////////////////////////////////
  // Hardware trigger: three stages, change counts when last two agree
  // The pin is asynchronous; the first stage may go metastable
  // Only agreement of the last two stages moves the filtered level
  // A rise is a single-cycle event against the filtered level
  logic [2:0] trg_sync;
  logic trg_level;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trg_sync <= 3'b000;
      trg_level <= 1'b0;
    end else begin
      trg_sync <= {trg_sync[1:0], hardware_trigger_input};
      if (trg_sync[2] == trg_sync[1]) begin
        trg_level <= trg_sync[2];
      end
    end
  end
  wire trg_rise = trg_sync[2] == trg_sync[1] && trg_sync[2] && !trg_level;
  ////////////////////////////////////////////////////////////////////////////
  // Start and stop decisions
  // Queue reaches its set length with this very write
  // Exact match: a write to an already full queue empties it instead
  wire queue_full_after = qi.count + 4'h1 == set_len;
  // Software start: control write, channel on, software trigger selected
  wire sw_start = wr_sc1 && !chan_off && !hw_mode && (!fifo_mode || queue_full_after);
  // Hardware start needs a live channel and, in queue mode, a full set
  wire hw_armed = hw_mode && channel_select != `ADCC_CH_OFF &&
    (!fifo_mode || queue_full);
  wire hw_start = trg_rise && hw_armed && state == ADCC_IDLE;
  wire halt = wr_sc1 && chan_off;
  wire conv_end = state == ADCC_CONV && timer == 16'h0001;
  wire last_of_set = !fifo_mode || qidx + 4'h1 >= set_len;
  // Compare with compare values: greater-or-equal or less-than
  function automatic logic cmp_true(input logic [9:0] v, input logic [9:0] ref_v,
    input logic gt);
    cmp_true = gt ? (v >= ref_v) : (v < ref_v);
  endfunction
  wire [9:0] cmp_ref = {compare_value_high[1:0], compare_value_low};
  wire cmp_ok = !compare_enable || cmp_true(sample_data, cmp_ref, compare_gt);
  // Flag set per conversion, or once at end of a set in queue mode
  wire set_done = conv_end && cmp_ok && last_of_set;
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ADCC_IDLE: begin
        if (sw_start || hw_start) begin
          next_state = ADCC_CONV;
        end
      end
      ADCC_CONV: begin
        if (conv_end) begin
          if (!last_of_set || continuous_enable) begin
            next_state = ADCC_WAIT;
          end else begin
            next_state = ADCC_IDLE;
          end
        end
      end
      ADCC_WAIT: begin
        next_state = ADCC_CONV;
      end
      default: begin
        next_state = ADCC_IDLE;
      end
    endcase
    // Register writes override the sequence: halt first, then restart
    if (halt) begin
      next_state = ADCC_IDLE;
    end else if (sw_start) begin
      next_state = ADCC_CONV;
    end
  end
  // State, timer and queue position
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ADCC_IDLE;
      timer <= 16'h0000;
      qidx <= 4'h0;
    end else begin
      state <= next_state;
      // Timer reloads on every entry to conversion and on every restart
      // It counts down to one, the cycle in which the sample is taken
      // Outside conversion it drains to zero and then stays there
      if (next_state == ADCC_CONV && (state != ADCC_CONV || sw_start)) begin
        timer <= 16'(CONV_CYCLES);
      end else if (timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end
      // Queue position restarts with each set, steps at each completion
      if (sw_start || hw_start || halt) begin
        qidx <= 4'h0;
      end else if (conv_end) begin
        qidx <= last_of_set ? 4'h0 : qidx + 4'h1;
      end
    end
  end
  assign qi.push = wr_sc1 && fifo_mode && !chan_off;
  assign qi.clear = halt || (wr_sc1 && fifo_mode && queue_full);
  assign qi.push_chan = wr_chan;
  assign qi.rd_ptr = qidx;
  assign active_channel = fifo_mode ? qi.rd_chan : channel_select;
  assign sample_strobe = conv_end;
  ////////////////////////////////////////////////////////////////////////////
  // Control register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_control_one <= `ADCC_RST_SC1;
      status_control_two <= `ADCC_RST_SC2;
      status_control_three <= `ADCC_RST_ZERO;
      status_control_four <= `ADCC_RST_ZERO;
      compare_value_high <= `ADCC_RST_ZERO;
      compare_value_low <= `ADCC_RST_ZERO;
      pin_control_one <= `ADCC_RST_ZERO;
    end else if (wr) begin
      case (addr)
        // Flag bit is kept apart; only the writable bits are stored
        `ADCC_OFS_SC1: begin
          status_control_one <= {1'b0, wdata[6:0]};
        end
        // Busy and queue flags are live views, never stored
        `ADCC_OFS_SC2: begin
          status_control_two <= {1'b0, wdata[6:4], 4'h0};
        end
        `ADCC_OFS_SC3: begin
          status_control_three <= wdata;
        end
        // Depth takes effect at once; queue mode and set length follow it directly
        `ADCC_OFS_SC4: begin
          status_control_four <= wdata;
        end
        `ADCC_OFS_CVH: begin
          compare_value_high <= wdata;
        end
        `ADCC_OFS_CVL: begin
          compare_value_low <= wdata;
        end
        `ADCC_OFS_PCTL: begin
          pin_control_one <= wdata;
        end
        // Result registers and unmapped offsets ignore writes
        default: begin
        end
      endcase
    end
  end
  // Results and done flag; a set on the same edge as a clear wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_high <= `ADCC_RST_ZERO;
      result_low <= `ADCC_RST_ZERO;
      conversion_done_flag <= 1'b0;
    end else begin
      if (conv_end && cmp_ok) begin
        result_high <= {6'h00, sample_data[9:8]};
        result_low <= sample_data[7:0];
      end
      if (set_done) begin
        conversion_done_flag <= 1'b1;
      end else if (wr_sc1 || rd_rl) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end
  // Level request, follows flag and enable
  assign done_irq = conversion_done_flag && done_interrupt_enable;
  ////////////////////////////////////////////////////////////////////////////
  // Read path, data one cycle after strobe
  logic [7:0] rd_mux;
  // Busy covers the gap between queued conversions as well
  wire busy = state != ADCC_IDLE;
  wire [7:0] sc2_view = {busy, status_control_two[6:4], qi.count == 4'h0,
    fifo_mode && queue_full, 2'b00};
  always_comb begin
    case (addr)
      `ADCC_OFS_SC1: rd_mux = {conversion_done_flag, status_control_one[6:0]};
      `ADCC_OFS_SC2: rd_mux = sc2_view;
      `ADCC_OFS_SC3: rd_mux = status_control_three;
      `ADCC_OFS_SC4: rd_mux = status_control_four;
      `ADCC_OFS_RH: rd_mux = result_high;
      `ADCC_OFS_RL: rd_mux = result_low;
      `ADCC_OFS_CVH: rd_mux = compare_value_high;
      `ADCC_OFS_CVL: rd_mux = compare_value_low;
      `ADCC_OFS_PCTL: rd_mux = pin_control_one;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end
endmodule

/* bench/adcc_ctrl_sva.sv */
// Port checker for the converter control block
`timescale 1ns/10ps
`include "adcc_defs.svh"
module adcc_ctrl_sva #(
  parameter int CONV_CYCLES = 4
) (
  input logic clk,
  input logic rst,
  input logic [15:0] addr,
  input logic [7:0] wdata,
  input logic wr,
  input logic rd,
  input logic [7:0] rdata,
  input logic hardware_trigger_input,
  input logic [9:0] sample_data,
  input logic [4:0] active_channel,
  input logic sample_strobe,
  input logic done_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Decoded accesses that clear the flag
  wire wr_sc1 = wr && addr == `ADCC_OFS_SC1;
  wire rd_rl = rd && addr == `ADCC_OFS_RL;
  logic [15:0] since_wr;
  // Saturates, so a long idle spell never wraps into a false early count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) since_wr <= 16'hffff;
    else if (wr_sc1) since_wr <= 16'h0000;
    else if (since_wr != 16'hffff) since_wr <= since_wr + 16'h0001;
  end
  ////////////////////////////////////////////////////////////
  AST_RDATA_QUIET: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  AST_STROBE_ONE: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe longer than one cycle");
  AST_IRQ_CAUSE: assert property ($rose(done_irq) |-> $past(sample_strobe))
    else $error("irq rose without a completion");
  AST_CLR_WR: assert property (wr_sc1 && !sample_strobe |=> !done_irq)
    else $error("irq kept after control write");
  AST_CLR_RD: assert property (rd_rl && !sample_strobe |=> !done_irq)
    else $error("irq kept after low result read");
  AST_IRQ_HOLD: assert property (done_irq && !wr_sc1 && !rd_rl |=> done_irq)
    else $error("irq dropped on its own");
  AST_HALT: assert property (wr_sc1 && wdata[4:0] == 5'h1f |=> !sample_strobe [*8])
    else $error("conversion after halt");
  AST_CONV_TIME: assert property (sample_strobe |-> since_wr >= CONV_CYCLES - 1)
    else $error("conversion ended too early");
  // Main scenarios
  COV_STROBE: cover property (sample_strobe);
  COV_IRQ: cover property ($rose(done_irq));
  COV_RL: cover property (rd_rl && done_irq);
endmodule
bind adcc_ctrl adcc_ctrl_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .hardware_trigger_input(hardware_trigger_input), .sample_data(sample_data),
  .active_channel(active_channel), .sample_strobe(sample_strobe), .done_irq(done_irq));

/* bench/adcc_ctrl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module adcc_ctrl_tb;
  localparam int CONV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hardware_trigger_input = 1'b0;
  logic [9:0] sample_data = 10'h2a5;
  logic [7:0] rdata;
  logic [4:0] active_channel;
  logic sample_strobe;
  logic done_irq;
  int n_fail = 0;
  int compares = 0;
  logic [15:0] ofs [10] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0014,
    16'h0015, 16'h0016, 16'h0017, 16'h30ac, 16'h0020};
  // Reset values in the same order; last entry is an unmapped offset
  logic [7:0] rst_exp [10] = '{8'h1f, 8'h08, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #5 clk = ~clk;
  adcc_ctrl #(.CONV_CYCLES(CONV)) u_dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .hardware_trigger_input(hardware_trigger_input), .sample_data(sample_data),
    .active_channel(active_channel), .sample_strobe(sample_strobe), .done_irq(done_irq));
  ////////////////////////////////////////////////////////////
  task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Each cycle waits a fresh edge, so strobes never double up
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check($sformatf("reg %h", a), rdata, exp);
  endtask
  // Bounded wait for the end of a conversion
  task wait_strobe(input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clk);
      #1 got = sample_strobe;
    end
  endtask
  task no_strobe(input int lim);
    logic got;
    wait_strobe(lim, got);
    check("stray strobe", got, 1'b0);
  endtask
  // Flag lands one edge after the strobe
  task done_after(input logic [4:0] ch, input logic exp);
    logic got;
    wait_strobe(4 * CONV + 8, got);
    if (got !== 1'b1) begin
      n_fail++;
      print_verdict;
    end
    check("channel", active_channel, ch);
    @(posedge clk);
    #1 check("done irq", done_irq, exp);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd_reg(ofs[i], rst_exp[i]);
    // Of results, compare, pin and unmapped, only compare and pin keep written data
    for (int i = 4; i < 10; i++) begin
      wr_reg(ofs[i], 8'h5a);
      rd_reg(ofs[i], (i < 6 || i == 9) ? 8'h00 : 8'h5a);
    end
    wr_reg(16'h0010, 8'h43);
    done_after(5'h03, 1'b1);
    rd_reg(16'h0010, 8'hc3);
    rd_reg(16'h0014, 8'h02);
    rd_reg(16'h0015, 8'ha5);
    check("irq after read", done_irq, 1'b0);
    no_strobe(12);
    wr_reg(16'h0010, 8'h01);
    wr_reg(16'h0010, 8'h02);
    done_after(5'h02, 1'b0);
    wr_reg(16'h0010, 8'h04);
    wr_reg(16'h0010, 8'h1f);
    no_strobe(12);
    check("idle channel", active_channel, 5'h1f);
    wr_reg(16'h0010, 8'h21);
    done_after(5'h01, 1'b0);
    done_after(5'h01, 1'b0);
    wr_reg(16'h0010, 8'h1f);
    // Hardware trigger held past the input filter
    wr_reg(16'h0011, 8'h40);
    wr_reg(16'h0010, 8'h45);
    no_strobe(12);
    hardware_trigger_input <= 1'b1;
    repeat (6) @(posedge clk);
    hardware_trigger_input <= 1'b0;
    done_after(5'h05, 1'b1);
    no_strobe(12);
    // Result 2a5 against reference 25a: less-than misses, at-or-above hits
    wr_reg(16'h0011, 8'h20);
    wr_reg(16'h0010, 8'h46);
    done_after(5'h06, 1'b0);
    wr_reg(16'h0011, 8'h30);
    wr_reg(16'h0010, 8'h46);
    done_after(5'h06, 1'b1);
    wr_reg(16'h0010, 8'h5f);
    #1 check("irq after write", done_irq, 1'b0);
    // Queue of three, converted in write order once full
    wr_reg(16'h0011, 8'h00);
    wr_reg(16'h0013, 8'h02);
    wr_reg(16'h0010, 8'h45);
    wr_reg(16'h0010, 8'h46);
    no_strobe(12);
    wr_reg(16'h0010, 8'h47);
    done_after(5'h05, 1'b0);
    done_after(5'h06, 1'b0);
    done_after(5'h07, 1'b1);
    no_strobe(20);
    print_verdict;
  end
endmodule
